// file: hdl/dps_map.vh
// bit positions, codes and timing constants of the dual loop serial control
`ifndef DPS_MAP_VH
`define DPS_MAP_VH

`define DPS_WORD_W      24
`define DPS_LATCH_RST   24'h000000
`define DPS_CTL_HI      1
`define DPS_CTL_LO      0
`define DPS_DST_IF_REF  2'h0
`define DPS_DST_IF_DIV  2'h1
`define DPS_DST_RF_REF  2'h2
`define DPS_DST_RF_DIV  2'h3

`define DPS_R_HI        16
`define DPS_R_LO        2
`define DPS_POL         17
`define DPS_TRI         18
`define DPS_SEL_LO      19
`define DPS_SEL_HI      20
`define DPS_CUR_HI      23
`define DPS_CUR_LO      21

`define DPS_A_HI        7
`define DPS_A_LO        2
`define DPS_B_HI        19
`define DPS_B_LO        8
`define DPS_PS_HI       21
`define DPS_PS_LO       20
`define DPS_PD          22
`define DPS_GAIN        23

`define DPS_MX_LOW      4'h0
`define DPS_MX_IF_DLK   4'h1
`define DPS_MX_IF_NDIV  4'h2
`define DPS_MX_IF_ALK   4'h3
`define DPS_MX_RF_DLK   4'h4
`define DPS_MX_IF_RDIV  4'h5
`define DPS_MX_BOTH_ALK 4'h6
`define DPS_MX_RF_RDIV  4'h7
`define DPS_MX_RF_NDIV  4'h8
`define DPS_MX_IF_RST   4'h9
`define DPS_MX_RF_RST   4'hA
`define DPS_MX_BOTH_RST 4'hB
`define DPS_MX_RF_ALK   4'hC
`define DPS_MX_FAST     4'hD
`define DPS_MX_HIGH     4'hE

`define DPS_SY_DATA     0
`define DPS_SY_SCLK     1
`define DPS_SY_LOAD     2
`define DPS_SY_REF      3
`define DPS_SY_IFFB     4
`define DPS_SY_RFFB     5
`define DPS_SY_W        6

`define DPS_CLK_NS      5
`define DPS_ABL_NS      3
`define DPS_LOCK_IN_NS  15
`define DPS_UNLOCK_NS   25
`define DPS_LOCK_RUN    2'h3

`endif

// file: hdl/dps_loop_section.v
// one synthesizer loop: dividers, phase comparator, lock detect, power-down
`timescale 1ns/100ps
`include "dps_map.vh"
module dps_loop_section (
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        ref_rise,
    input  wire        fb_rise,
    input  wire [14:0] r_count,
    input  wire [5:0]  a_count,
    input  wire [11:0] b_count,
    input  wire        polarity,
    input  wire        pump_tristate,
    input  wire        counter_reset,
    input  wire        powerdown_bit,
    output wire        pump_up,
    output wire        pump_dn,
    output wire        pump_hiz,
    output reg         dlock_q,
    output wire        alock_level,
    output wire        powered,
    output wire        modulus_ctl,
    output reg         r_pulse_q,
    output reg         n_pulse_q
);
    localparam PW_ON  = 2'b00;
    localparam PW_HIZ = 2'b01;
    localparam PW_OFF = 2'b10;
    // least time rounds up, longest rounds down, never below one cycle
    localparam [2:0] ABL_CYC_RAW = (`DPS_ABL_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS;
    localparam [2:0] ABL_CYC     = (ABL_CYC_RAW == 3'h0) ? 3'h1 : ABL_CYC_RAW;
    localparam [7:0] LOCK_IN_CYC = `DPS_LOCK_IN_NS / `DPS_CLK_NS;
    localparam [7:0] UNLOCK_CYC  = `DPS_UNLOCK_NS / `DPS_CLK_NS;

    reg  [1:0]  pw_q;
    reg  [1:0]  pw_d;
    reg  [14:0] r_cnt_q;
    reg  [5:0]  a_cnt_q;
    reg  [11:0] b_cnt_q;
    reg         up_q;
    reg         dn_q;
    reg  [2:0]  abl_q;
    reg  [7:0]  err_q;
    reg  [1:0]  good_q;
    wire        hold;
    wire [14:0] r_next;
    wire [11:0] b_next;

    always @* begin
        pw_d = pw_q;
        case (pw_q)
            PW_ON: begin
                if (powerdown_bit) begin
                    pw_d = pump_tristate ? PW_OFF : PW_HIZ;
                end
            end
            PW_HIZ:  pw_d = powerdown_bit ? PW_OFF : PW_ON;
            PW_OFF: begin
                if (!powerdown_bit) begin
                    pw_d = PW_ON;
                end
            end
            default: pw_d = PW_ON;
        endcase
    end

    assign hold        = counter_reset | (pw_q == PW_OFF);
    assign powered     = (pw_q != PW_OFF);
    assign pump_hiz    = pump_tristate | counter_reset | (pw_q != PW_ON);
    assign pump_up     = polarity ? up_q : dn_q;
    assign pump_dn     = polarity ? dn_q : up_q;
    // low whenever a pump pulse is out: narrow dips once locked
    assign alock_level = ~(up_q | dn_q);
    assign modulus_ctl = (a_cnt_q < a_count);
    assign r_next      = r_cnt_q + 15'h0001;
    assign b_next      = b_cnt_q + 12'h001;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pw_q      <= PW_ON;
            r_cnt_q   <= 15'h0000;
            a_cnt_q   <= 6'h00;
            b_cnt_q   <= 12'h000;
            r_pulse_q <= 1'b0;
            n_pulse_q <= 1'b0;
        end else begin
            pw_q      <= pw_d;
            r_pulse_q <= 1'b0;
            n_pulse_q <= 1'b0;
            if (hold) begin
                // both counters parked together so they restart aligned
                r_cnt_q <= 15'h0000;
                a_cnt_q <= 6'h00;
                b_cnt_q <= 12'h000;
            end else begin
                if (ref_rise) begin
                    if (r_next >= r_count) begin
                        r_cnt_q   <= 15'h0000;
                        r_pulse_q <= 1'b1;
                    end else begin
                        r_cnt_q <= r_next;
                    end
                end
                if (fb_rise) begin
                    if (b_next >= b_count) begin
                        a_cnt_q   <= 6'h00;
                        b_cnt_q   <= 12'h000;
                        n_pulse_q <= 1'b1;
                    end else begin
                        b_cnt_q <= b_next;
                        if (modulus_ctl) begin
                            a_cnt_q <= a_cnt_q + 6'h01;
                        end
                    end
                end
            end
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            up_q    <= 1'b0;
            dn_q    <= 1'b0;
            abl_q   <= 3'h0;
            err_q   <= 8'h00;
            good_q  <= 2'h0;
            dlock_q <= 1'b0;
        end else if (hold) begin
            up_q    <= 1'b0;
            dn_q    <= 1'b0;
            abl_q   <= 3'h0;
            err_q   <= 8'h00;
            good_q  <= 2'h0;
            dlock_q <= 1'b0;
        end else if (up_q && dn_q) begin
            // both on: hold for the antibacklash width, then judge the cycle
            if (abl_q + 3'h1 >= ABL_CYC) begin
                up_q  <= 1'b0;
                dn_q  <= 1'b0;
                abl_q <= 3'h0;
                err_q <= 8'h00;
                if (err_q < LOCK_IN_CYC) begin
                    if (good_q == `DPS_LOCK_RUN - 2'h1) begin
                        dlock_q <= 1'b1;
                    end
                    if (good_q != `DPS_LOCK_RUN) begin
                        good_q <= good_q + 2'h1;
                    end
                end else begin
                    good_q <= 2'h0;
                    if (err_q > UNLOCK_CYC) begin
                        dlock_q <= 1'b0;
                    end
                end
            end else begin
                abl_q <= abl_q + 3'h1;
            end
        end else begin
            if (r_pulse_q) begin
                up_q <= 1'b1;
            end
            if (n_pulse_q) begin
                dn_q <= 1'b1;
            end
            if ((up_q ^ dn_q) && (err_q != 8'hFF)) begin
                err_q <= err_q + 8'h01;
            end
        end
    end
endmodule // dps_loop_section

// file: hdl/dps_serial_control.v
// three-wire programmed control of the IF and RF synthesizer loops
`timescale 1ns/100ps
`include "dps_map.vh"
// Functional notes
// - each comparison holds both pump pulses on for a short fixed antibacklash width.
// - test output source chosen by IF and RF select bits of reference latches.
// - digital lock rises after three consecutive cycles with error under 15 ns.
// - digital lock stays until a cycle shows error above 25 ns.
// - analog lock is open drain, high with narrow low dips when locked.
// - host sends MSB first; one bit shifts in per serial clock rise.
// - load strobe rise copies the word into exactly one latch.
// - two lowest bits choose IF ref, IF div, RF ref or RF div.
// - reference latches hold the reference count from bit two upward.
// - IF divider latch holds swallow, main count, prescaler, power-down, gain.
// - RF divider latch uses the IF layout, power-down bit 22, gain 23.
// - combined analog lock shows locked only while both loops are locked.
// - counter reset modes hold counters and tristate the pump per section.
// - released counters restart aligned within one prescaler cycle.
// - fast acquisition grounds the test output while RF gain bit is one.
// - power-down with pump active first tristates the pump, then powers down.
// - power-down with pump already tristated takes effect at the latching strobe.
// - any power-down parks the section counters and debiases its input.
// - shift register and latches keep working during every power-down.
// - latching a zero power-down bit restores the section immediately.
// - IF tristate bit one floats the IF pump, zero is normal.
module dps_serial_control (
    input  wire       clk_sys,
    input  wire       resetn,
    input  wire       ser_data,
    input  wire       ser_clk,
    input  wire       load_strobe,
    input  wire       ref_in,
    input  wire       if_fb_in,
    input  wire       rf_fb_in,
    output reg        test_select_output,
    output reg        test_select_output_oe_n,
    output reg        if_pump_up,
    output reg        if_pump_dn,
    output reg        if_pump_hiz,
    output reg        rf_pump_up,
    output reg        rf_pump_dn,
    output reg        rf_pump_hiz,
    output reg        if_modulus_ctl,
    output reg        rf_modulus_ctl,
    output reg [1:0]  if_prescale_sel,
    output reg [1:0]  rf_prescale_sel,
    output reg [2:0]  if_pump_current_field,
    output reg [2:0]  rf_pump_current_field,
    output reg        if_pump_gain,
    output reg        rf_pump_gain,
    output reg        if_input_bias,
    output reg        rf_input_bias,
    output reg        ref_osc_enable
);
    // per bit: keep the old level unless the two later stages agree
    function [`DPS_SY_W-1:0] agreed;
        input [`DPS_SY_W-1:0] s2;
        input [`DPS_SY_W-1:0] s3;
        input [`DPS_SY_W-1:0] old;
        begin
            agreed = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & old);
        end
    endfunction

    // a floated pump never shows a pulse on its pin
    function gate_pump;
        input pulse;
        input hiz;
        begin
            gate_pump = pulse & ~hiz;
        end
    endfunction

    function mode_is;
        input [3:0] code;
        input [3:0] first;
        input [3:0] second;
        begin
            mode_is = (code == first) || (code == second);
        end
    endfunction

    reg  [`DPS_SY_W-1:0]   sy1_q;
    reg  [`DPS_SY_W-1:0]   sy2_q;
    reg  [`DPS_SY_W-1:0]   sy3_q;
    reg  [`DPS_SY_W-1:0]   lvl_q;
    reg  [`DPS_SY_W-1:0]   rise_q;
    wire [`DPS_SY_W-1:0]   lvl_d;
    wire [`DPS_SY_W-1:0]   pins;

    reg  [`DPS_WORD_W-1:0] shift_q;
    reg  [`DPS_WORD_W-1:0] if_reference_latch_q;
    reg  [`DPS_WORD_W-1:0] if_divider_latch_q;
    reg  [`DPS_WORD_W-1:0] rf_reference_latch_q;
    reg  [`DPS_WORD_W-1:0] rf_divider_latch_q;

    wire [3:0] mux_code;
    wire       if_counter_reset;
    wire       rf_counter_reset;
    wire       fast_acq;
    wire       fast_pull;
    reg        mux_d;
    reg        mux_oe_n_d;

    wire       if_up;
    wire       if_dn;
    wire       if_hiz;
    wire       if_dlock;
    wire       if_alock;
    wire       if_pw;
    wire       if_mod;
    wire       if_rdiv;
    wire       if_ndiv;
    wire       rf_up;
    wire       rf_dn;
    wire       rf_hiz;
    wire       rf_dlock;
    wire       rf_alock;
    wire       rf_pw;
    wire       rf_mod;
    wire       rf_rdiv;
    wire       rf_ndiv;

    assign pins  = {rf_fb_in, if_fb_in, ref_in, load_strobe, ser_clk, ser_data};
    assign lvl_d = agreed(sy2_q, sy3_q, lvl_q);

    // pins are asynchronous to clk_sys; three stages and an agreement check
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sy1_q  <= {`DPS_SY_W{1'b0}};
            sy2_q  <= {`DPS_SY_W{1'b0}};
            sy3_q  <= {`DPS_SY_W{1'b0}};
            lvl_q  <= {`DPS_SY_W{1'b0}};
            rise_q <= {`DPS_SY_W{1'b0}};
        end else begin
            sy1_q  <= pins;
            sy2_q  <= sy1_q;
            sy3_q  <= sy2_q;
            lvl_q  <= lvl_d;
            rise_q <= lvl_d & ~lvl_q;
        end
    end

    // shifting and latching never depend on power-down state
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shift_q              <= `DPS_LATCH_RST;
            if_reference_latch_q <= `DPS_LATCH_RST;
            if_divider_latch_q   <= `DPS_LATCH_RST;
            rf_reference_latch_q <= `DPS_LATCH_RST;
            rf_divider_latch_q   <= `DPS_LATCH_RST;
        end else begin
            if (rise_q[`DPS_SY_SCLK]) begin
                // earlier bits move up, so the first bit sent ends as bit 23
                shift_q <= {shift_q[`DPS_WORD_W-2:0], lvl_q[`DPS_SY_DATA]};
            end
            if (rise_q[`DPS_SY_LOAD]) begin
                case (shift_q[`DPS_CTL_HI:`DPS_CTL_LO])
                    `DPS_DST_IF_REF: if_reference_latch_q <= shift_q;
                    `DPS_DST_IF_DIV: if_divider_latch_q   <= shift_q;
                    `DPS_DST_RF_REF: rf_reference_latch_q <= shift_q;
                    `DPS_DST_RF_DIV: rf_divider_latch_q   <= shift_q;
                    default:         if_reference_latch_q <= if_reference_latch_q;
                endcase
            end
        end
    end

    assign mux_code = {rf_reference_latch_q[`DPS_SEL_HI], rf_reference_latch_q[`DPS_SEL_LO],
                       if_reference_latch_q[`DPS_SEL_HI], if_reference_latch_q[`DPS_SEL_LO]};
    assign if_counter_reset = mode_is(mux_code, `DPS_MX_IF_RST, `DPS_MX_BOTH_RST);
    assign rf_counter_reset = mode_is(mux_code, `DPS_MX_RF_RST, `DPS_MX_BOTH_RST);
    assign fast_acq         = (mux_code == `DPS_MX_FAST);
    assign fast_pull        = fast_acq & rf_divider_latch_q[`DPS_GAIN];

    dps_loop_section u_if_loop (
        .clk_sys       (clk_sys),
        .resetn        (resetn),
        .ref_rise      (rise_q[`DPS_SY_REF]),
        .fb_rise       (rise_q[`DPS_SY_IFFB]),
        .r_count       (if_reference_latch_q[`DPS_R_HI:`DPS_R_LO]),
        .a_count       (if_divider_latch_q[`DPS_A_HI:`DPS_A_LO]),
        .b_count       (if_divider_latch_q[`DPS_B_HI:`DPS_B_LO]),
        .polarity      (if_reference_latch_q[`DPS_POL]),
        .pump_tristate (if_reference_latch_q[`DPS_TRI]),
        .counter_reset (if_counter_reset),
        .powerdown_bit (if_divider_latch_q[`DPS_PD]),
        .pump_up       (if_up),
        .pump_dn       (if_dn),
        .pump_hiz      (if_hiz),
        .dlock_q       (if_dlock),
        .alock_level   (if_alock),
        .powered       (if_pw),
        .modulus_ctl   (if_mod),
        .r_pulse_q     (if_rdiv),
        .n_pulse_q     (if_ndiv)
    );

    dps_loop_section u_rf_loop (
        .clk_sys       (clk_sys),
        .resetn        (resetn),
        .ref_rise      (rise_q[`DPS_SY_REF]),
        .fb_rise       (rise_q[`DPS_SY_RFFB]),
        .r_count       (rf_reference_latch_q[`DPS_R_HI:`DPS_R_LO]),
        .a_count       (rf_divider_latch_q[`DPS_A_HI:`DPS_A_LO]),
        .b_count       (rf_divider_latch_q[`DPS_B_HI:`DPS_B_LO]),
        .polarity      (rf_reference_latch_q[`DPS_POL]),
        .pump_tristate (rf_reference_latch_q[`DPS_TRI]),
        .counter_reset (rf_counter_reset),
        .powerdown_bit (rf_divider_latch_q[`DPS_PD]),
        .pump_up       (rf_up),
        .pump_dn       (rf_dn),
        .pump_hiz      (rf_hiz),
        .dlock_q       (rf_dlock),
        .alock_level   (rf_alock),
        .powered       (rf_pw),
        .modulus_ctl   (rf_mod),
        .r_pulse_q     (rf_rdiv),
        .n_pulse_q     (rf_ndiv)
    );

    // oe_n low means the pin is driven; open-drain modes only ever pull low
    always @* begin
        mux_d      = 1'b0;
        mux_oe_n_d = 1'b0;
        case (mux_code)
            `DPS_MX_LOW:      mux_d = 1'b0;
            `DPS_MX_HIGH:     mux_d = 1'b1;
            `DPS_MX_IF_DLK:   mux_d = if_dlock;
            `DPS_MX_RF_DLK:   mux_d = rf_dlock;
            `DPS_MX_IF_NDIV:  mux_d = if_ndiv;
            `DPS_MX_RF_NDIV:  mux_d = rf_ndiv;
            `DPS_MX_IF_RDIV:  mux_d = if_rdiv;
            `DPS_MX_RF_RDIV:  mux_d = rf_rdiv;
            `DPS_MX_IF_ALK:   mux_oe_n_d = if_alock;
            `DPS_MX_RF_ALK:   mux_oe_n_d = rf_alock;
            `DPS_MX_BOTH_ALK: mux_oe_n_d = if_alock & rf_alock;
            `DPS_MX_FAST:     mux_oe_n_d = ~fast_pull;
            default:          mux_d = 1'b0;
        endcase
    end

    // every output is registered to keep pin timing independent of decode depth
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            test_select_output      <= 1'b0;
            test_select_output_oe_n <= 1'b0;
            if_modulus_ctl          <= 1'b0;
            rf_modulus_ctl          <= 1'b0;
            if_input_bias           <= 1'b0;
            rf_input_bias           <= 1'b0;
            ref_osc_enable          <= 1'b0;
        end else begin
            test_select_output      <= mux_d;
            test_select_output_oe_n <= mux_oe_n_d;
            if_modulus_ctl          <= if_mod;
            rf_modulus_ctl          <= rf_mod;
            if_input_bias           <= if_pw;
            rf_input_bias           <= rf_pw;
            // reference buffer stays up unless both sections are down
            ref_osc_enable          <= if_pw | rf_pw;
        end
    end

    // pumps come out of reset floated
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            if_pump_up              <= 1'b0;
            if_pump_dn              <= 1'b0;
            if_pump_hiz             <= 1'b1;
            rf_pump_up              <= 1'b0;
            rf_pump_dn              <= 1'b0;
            rf_pump_hiz             <= 1'b1;
        end else begin
            if_pump_up              <= gate_pump(if_up, if_hiz);
            if_pump_dn              <= gate_pump(if_dn, if_hiz);
            if_pump_hiz             <= if_hiz;
            rf_pump_up              <= gate_pump(rf_up, rf_hiz);
            rf_pump_dn              <= gate_pump(rf_dn, rf_hiz);
            rf_pump_hiz             <= rf_hiz;
        end
    end

    // plain copies of latch fields for the analog side
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            if_prescale_sel         <= 2'h0;
            rf_prescale_sel         <= 2'h0;
            if_pump_current_field   <= 3'h0;
            rf_pump_current_field   <= 3'h0;
            if_pump_gain            <= 1'b0;
            rf_pump_gain            <= 1'b0;
        end else begin
            if_prescale_sel         <= if_divider_latch_q[`DPS_PS_HI:`DPS_PS_LO];
            rf_prescale_sel         <= rf_divider_latch_q[`DPS_PS_HI:`DPS_PS_LO];
            if_pump_current_field   <= if_reference_latch_q[`DPS_CUR_HI:`DPS_CUR_LO];
            rf_pump_current_field   <= rf_reference_latch_q[`DPS_CUR_HI:`DPS_CUR_LO];
            if_pump_gain            <= if_divider_latch_q[`DPS_GAIN];
            rf_pump_gain            <= rf_divider_latch_q[`DPS_GAIN];
        end
    end
endmodule // dps_serial_control

// file: sim/dps_checker.sv
// pin-level assertions for the serial control block
`timescale 1ns/100ps
module dps_checker (
    input wire       clk_sys,
    input wire       resetn,
    input wire       load_strobe,
    input wire       if_pump_up,
    input wire       if_pump_dn,
    input wire       if_pump_hiz,
    input wire       rf_pump_up,
    input wire       rf_pump_dn,
    input wire       rf_pump_hiz,
    input wire       if_input_bias,
    input wire       rf_input_bias,
    input wire       ref_osc_enable,
    input wire       rf_pump_gain,
    input wire [1:0] if_prescale_sel
);
    logic [3:0] since_q;
    logic [3:0] since_d;
    logic       strobe_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // latched fields may only move within a short window after a strobe rise
    always @* begin
        since_d = since_q;
        if (load_strobe && !strobe_q)
            since_d = 4'h0;
        else if (since_q != 4'hF)
            since_d = since_q + 4'h1;
    end
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            since_q <= 4'hF;
            strobe_q <= 1'b0;
        end else begin
            since_q <= since_d;
            strobe_q <= load_strobe;
        end
    end
    property p_if_hiz; if_pump_hiz |-> !if_pump_up && !if_pump_dn; endproperty
    property p_rf_hiz; rf_pump_hiz |-> !(rf_pump_up || rf_pump_dn); endproperty
    property p_if_abl; if_pump_up && if_pump_dn |=> !(if_pump_up && if_pump_dn); endproperty
    property p_rf_abl; rf_pump_up && rf_pump_dn |=> !(rf_pump_up && rf_pump_dn); endproperty
    property p_osc; !ref_osc_enable |-> !if_input_bias && !rf_input_bias; endproperty
    property p_if_sync; $fell(if_input_bias) |-> $past(if_pump_hiz); endproperty
    property p_pd_quiet; !if_input_bias |-> !if_pump_up && !if_pump_dn; endproperty
    property p_if_hold; !$stable(if_prescale_sel) |-> since_q < 4'hC; endproperty
    property p_rf_hold; !$stable(rf_pump_gain) |-> since_q < 4'hC; endproperty
    a_if_hiz: assert property (p_if_hiz) else $error("if pump pulses while floated");
    a_rf_hiz: assert property (p_rf_hiz) else $error("rf pump pulses while floated");
    a_if_abl: assert property (p_if_abl) else $error("if overlap pulse too long");
    a_rf_abl: assert property (p_rf_abl) else $error("rf overlap pulse too long");
    a_osc: assert property (p_osc) else $error("oscillator off with a section powered");
    a_if_sync: assert property (p_if_sync) else $error("if powered down before pump floated");
    a_pd_quiet: assert property (p_pd_quiet) else $error("if pump active while powered down");
    a_if_hold: assert property (p_if_hold) else $error("if prescaler changed without strobe");
    a_rf_hold: assert property (p_rf_hold) else $error("rf gain changed without strobe");
    c_abl: cover property (if_pump_up && if_pump_dn);
    c_pd: cover property ($fell(if_input_bias));
    c_osc: cover property (!ref_osc_enable);
endmodule // dps_checker
bind dps_serial_control dps_checker chk_u (.clk_sys(clk_sys), .resetn(resetn), .load_strobe(load_strobe),
    .if_pump_up(if_pump_up), .if_pump_dn(if_pump_dn), .if_pump_hiz(if_pump_hiz), .rf_pump_up(rf_pump_up),
    .rf_pump_dn(rf_pump_dn), .rf_pump_hiz(rf_pump_hiz), .if_input_bias(if_input_bias),
    .rf_input_bias(rf_input_bias), .ref_osc_enable(ref_osc_enable), .rf_pump_gain(rf_pump_gain),
    .if_prescale_sel(if_prescale_sel));

// file: sim/dps_host.sv
// host controller driving the three-wire programming port
`timescale 1ns/100ps
module dps_host (
    input  wire  clk_sys,
    output logic ser_data,
    output logic ser_clk,
    output logic load_strobe
);
    int slow = 8;
    task automatic half();
        repeat (slow) @(posedge clk_sys);
        #1;
    endtask
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i];
            half();
            ser_clk = 1'b1;
            half();
            ser_clk = 1'b0;
        end
        // no stale bit left on the idle data line
        ser_data = ~w[0];
        load_strobe = 1'b1;
        half();
        half();
        load_strobe = 1'b0;
    endtask
    initial begin
        ser_data = 1'b0;
        ser_clk = 1'b0;
        load_strobe = 1'b0;
    end
endmodule // dps_host

// file: sim/testbench.sv
// self-checking bench of the three-wire serial control
`timescale 1ns/100ps
module testbench;
    logic        clk_sys;
    logic        resetn;
    logic [3:0]  ph_q;
    logic [23:0] lat [4];
    logic [23:0] lf;
    logic [23:0] w;
    int          mismatches;
    int          num_checks;
    int          cyc;
    wire         ser_data, ser_clk, load_strobe, mux_q, mux_oe_n, if_hiz, rf_hiz;
    wire         if_gain, rf_gain, if_bias, rf_bias, osc_en, if_mod, rf_mod;
    wire [1:0]   if_ps, rf_ps;
    wire [2:0]   if_cur, rf_cur;
    logic [23:0] corner [10] = '{24'h180002, 24'h100000, 24'h7ABCDD, 24'h1C0000, 24'h812345,
                                 24'hC00005, 24'hC00007, 24'h080000, 24'h000003, 24'h100002};
    dps_host host_u (.clk_sys(clk_sys), .ser_data(ser_data), .ser_clk(ser_clk), .load_strobe(load_strobe));
    dps_serial_control dut_u (.clk_sys(clk_sys), .resetn(resetn), .ser_data(ser_data), .ser_clk(ser_clk),
        .load_strobe(load_strobe), .ref_in(ph_q[3]), .if_fb_in(ph_q[2]), .rf_fb_in(ph_q[1]),
        .test_select_output(mux_q), .test_select_output_oe_n(mux_oe_n), .if_pump_up(), .if_pump_dn(),
        .if_pump_hiz(if_hiz), .rf_pump_up(), .rf_pump_dn(), .rf_pump_hiz(rf_hiz), .if_modulus_ctl(if_mod),
        .rf_modulus_ctl(rf_mod), .if_prescale_sel(if_ps), .rf_prescale_sel(rf_ps), .if_pump_current_field(if_cur),
        .rf_pump_current_field(rf_cur), .if_pump_gain(if_gain), .rf_pump_gain(rf_gain),
        .if_input_bias(if_bias), .rf_input_bias(rf_bias), .ref_osc_enable(osc_en));
    function automatic logic [23:0] nxt(input logic [23:0] s);
        return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
    endfunction
    function automatic logic [1:0] exp_mux(input logic [3:0] c);
        case (c)
            4'hE: return 2'b01;
            4'hD: return {~lat[3][23], 1'b0};
            default: return 2'b00;
        endcase
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic check_all();
        logic [3:0] c;
        logic       ipd;
        logic       rpd;
        c = {lat[2][20:19], lat[0][20:19]};
        ipd = lat[1][22];
        rpd = lat[3][22];
        chk({if_ps, rf_ps, if_gain, rf_gain}, {lat[1][21:20], lat[3][21:20], lat[1][23], lat[3][23]});
        chk({if_cur, rf_cur}, {lat[0][23:21], lat[2][23:21]});
        chk({if_bias, rf_bias, osc_en}, {~ipd, ~rpd, ~(ipd & rpd)});
        chk({if_hiz, rf_hiz}, {lat[0][18] | ipd | c == 9 | c == 11, lat[2][18] | rpd | c == 10 | c == 11});
        chk({if_mod & ipd, rf_mod & rpd}, {ipd & |lat[1][7:2], rpd & |lat[3][7:2]});
        // lock and divider codes depend on loop phase, so only static codes are compared
        if (c == 0 || (c > 8 && c != 12))
            chk({mux_oe_n, mux_q}, exp_mux(c));
    endtask
    task automatic wr(input logic [23:0] v);
        host_u.send(v);
        lat[v[1:0]] = v;
        repeat (20) @(posedge clk_sys);
        #1;
        check_all();
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        #1;
        ph_q = ph_q + 4'h1;
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            $display("BAD %0t run timed out", $time);
            give_verdict();
        end
    end
    initial begin
        resetn = 1'b0;
        ph_q = 4'h0;
        lf = 24'h00000B;
        foreach (lat[i])
            lat[i] = 24'h0;
        repeat (5) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        check_all();
        foreach (corner[i])
            wr(corner[i]);
        $display("corner sequence done");
        repeat (40) begin
            lf = nxt(lf);
            w = lf;
            if (w[1:0] == 2'b00)
                w[19] = w[19] | ~w[20];
            if (w[1:0] == 2'b10)
                w[20] = 1'b1;
            wr(w);
        end
        $display("random sequence done");
        resetn = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({if_hiz, rf_hiz, if_bias, osc_en}, 8'h0C);
        resetn = 1'b1;
        foreach (lat[i])
            lat[i] = 24'h0;
        repeat (4) @(posedge clk_sys);
        #1;
        check_all();
        $display("second reset done");
        give_verdict();
    end
endmodule // testbench
